// File: wwdt_cfg.svh
// Constants for the windowed watchdog: offsets, fields, reset values, timing.
`ifndef WWDT_CFG_SVH
`define WWDT_CFG_SVH
// ==========================================
// Register offsets and fields
`define WWDT_OFS_CTRL 8'h00
`define WWDT_OFS_STATUS 8'h04
`define WWDT_OFS_KEY 8'h08
`define WWDT_KEY_VAL 8'hD8
`define WWDT_LOCK_BIT 7
`define WWDT_BUSY_BIT 0
`define WWDT_CTRL_RST 8'h00
`define WWDT_HSIZE_WORD 3'h2
// ==========================================
// Timing
`define WWDT_CLK_HZ 10000000
`define WWDT_TICK_HZ 1000
`define WWDT_TICK_DIV (`WWDT_CLK_HZ / `WWDT_TICK_HZ)
`define WWDT_MIN_TO_MS 8
`define WWDT_BASE_TICKS 14'((`WWDT_MIN_TO_MS * `WWDT_TICK_HZ) / 1000)
`define WWDT_MAX_SEL 4'hB
`define WWDT_MAX_TICKS 14'h2000
`define WWDT_SYNC_TICKS 2'h2
`define WWDT_PROT_CYC 4'h8
`endif

// File: wwdt_pkg.sv
// Types shared by the windowed watchdog.
package wwdt_pkg;
  typedef enum logic [1:0] {
    WWDT_IDLE = 2'h0,
    WWDT_WAIT = 2'h1,
    WWDT_CLOSED = 2'h3,
    WWDT_OPEN = 2'h2
  } wwdt_state_type;
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } wwdt_ctrl_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } wwdt_aphase_type;
endpackage

// File: wwdt_top.sv
// Windowed watchdog timer with AHB-Lite register access.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "wwdt_cfg.svh"
module wwdt_top #(
  parameter int TICK_DIV = `WWDT_TICK_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic watchdog_restart_instr,
  input wire logic debug_halt,
  input wire logic debug_mode,
  input wire logic [7:0] watchdog_boot_fuse,
  output logic wdt_sys_reset
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  function automatic logic [13:0] wwdt_limit(input logic [3:0] sel);
    if (sel == 4'h0) begin
      wwdt_limit = 14'h0000;
    end else if (sel > `WWDT_MAX_SEL) begin
      wwdt_limit = `WWDT_MAX_TICKS;
    end else begin
      wwdt_limit = `WWDT_BASE_TICKS << (sel - 4'h1);
    end
  endfunction

  logic boot_done;
  logic [13:0] div_cnt;
  logic tick;
  wwdt_pkg::wwdt_aphase_type ap;
  logic [3:0] prot_cnt;
  logic prot_open;
  wwdt_pkg::wwdt_ctrl_type ctrl_reg;
  wwdt_pkg::wwdt_ctrl_type act_ctrl;
  logic sync_busy;
  logic lock;
  logic rst_pend;
  logic [1:0] rst_cnt;
  logic rst_do;
  wwdt_pkg::wwdt_state_type state;
  logic [13:0] count;
  logic [13:0] cur_limit;
  logic timeout_hit;
  logic early_hit;
  logic fire;
  logic wr_en;
  logic apply;

  // ==========================================
  // Boot: the fuse is caught one edge after reset release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= 1'b1;
    end
  end

  // ==========================================
  // Counter tick
  // The tick stands in for the low-power oscillator but is divided from hclk,
  // so a lost bus clock stalls the tick and the reset path with it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 14'h0000;
      tick <= 1'b0;
    end else if (div_cnt == 14'(TICK_DIV - 1)) begin
      div_cnt <= 14'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= 14'(div_cnt + 14'h0001);
      tick <= 1'b0;
    end
  end

  // ==========================================
  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap.valid <= hsel & htrans[1] & hready & (hsize == `WWDT_HSIZE_WORD);
      ap.write <= hwrite;
      ap.addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_en = ap.valid & ap.write;

  // Read data is latched in the address phase so it leaves a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hsel & htrans[1] & hready & !hwrite) begin
      case (haddr[7:0])
        `WWDT_OFS_CTRL: hrdata <= {24'h000000, ctrl_reg};
        `WWDT_OFS_STATUS: hrdata <= {24'h000000, lock, 6'h00, sync_busy};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // Timed write protection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_cnt <= 4'h0;
    end else if (wr_en && ap.addr == `WWDT_OFS_KEY && hwdata[7:0] == `WWDT_KEY_VAL) begin
      prot_cnt <= `WWDT_PROT_CYC;
    end else if (wr_en && (ap.addr == `WWDT_OFS_CTRL || ap.addr == `WWDT_OFS_STATUS)) begin
      prot_cnt <= 4'h0;
    end else if (prot_cnt != 4'h0) begin
      prot_cnt <= prot_cnt - 4'h1;
    end
  end

  assign prot_open = (prot_cnt != 4'h0);

  // ==========================================
  // Control register and its hand-over to the counter side
  assign apply = sync_busy & tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `WWDT_CTRL_RST;
      sync_busy <= 1'b0;
    end else if (!boot_done) begin
      ctrl_reg <= watchdog_boot_fuse;
    end else if (wr_en && ap.addr == `WWDT_OFS_CTRL && prot_open && !lock && !sync_busy) begin
      ctrl_reg <= hwdata[7:0];
      sync_busy <= 1'b1;
    end else if (apply) begin
      sync_busy <= 1'b0;
    end
  end

  chk_unprot_ignored: assert property (
    wr_en && ap.addr == `WWDT_OFS_CTRL && !prot_open && boot_done |=> $stable(ctrl_reg)
  ) else $error("unprotected control write changed control");

  chk_lock_freezes: assert property (
    lock && boot_done |=> $stable(ctrl_reg)
  ) else $error("control changed while locked");

  // ==========================================
  // Lock bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock <= 1'b0;
    end else if (!boot_done) begin
      lock <= (watchdog_boot_fuse[3:0] != 4'h0);
    end else if (wr_en && ap.addr == `WWDT_OFS_STATUS && prot_open) begin
      if (hwdata[`WWDT_LOCK_BIT]) begin
        lock <= 1'b1;
      end else if (debug_mode) begin
        lock <= 1'b0;
      end
    end
  end

  chk_lock_clear_dbg: assert property (
    $fell(lock) |-> $past(debug_mode) && $past(prot_open)
  ) else $error("lock cleared outside debug mode");

  // ==========================================
  // Restart synchronisation over counter ticks
  assign rst_do = rst_pend & tick & (rst_cnt == `WWDT_SYNC_TICKS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_pend <= 1'b0;
      rst_cnt <= 2'h0;
    end else if (debug_halt) begin
      rst_pend <= 1'b0;
      rst_cnt <= 2'h0;
    end else if (rst_do) begin
      rst_pend <= 1'b0;
      rst_cnt <= 2'h0;
    end else if (rst_pend) begin
      if (tick) begin
        rst_cnt <= 2'(rst_cnt + 2'h1);
      end
    end else if (watchdog_restart_instr) begin
      rst_pend <= 1'b1;
      rst_cnt <= 2'h0;
    end
  end

  chk_restart_held: assert property (
    rst_pend && !tick && !debug_halt |=> rst_pend && $stable(rst_cnt)
  ) else $error("pending restart disturbed between ticks");

  // ==========================================
  // Counter and window state machine
  assign cur_limit = (state == wwdt_pkg::WWDT_CLOSED) ?
                     wwdt_limit(act_ctrl.window) : wwdt_limit(act_ctrl.period);
  assign timeout_hit = tick && (state == wwdt_pkg::WWDT_WAIT || state == wwdt_pkg::WWDT_OPEN) &&
                       14'(count + 14'h0001) >= cur_limit && !rst_do;
  assign early_hit = rst_do && state == wwdt_pkg::WWDT_CLOSED;
  assign fire = !debug_halt && !apply && boot_done && (timeout_hit || early_hit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_ctrl <= `WWDT_CTRL_RST;
      state <= wwdt_pkg::WWDT_IDLE;
      count <= 14'h0000;
      wdt_sys_reset <= 1'b0;
    end else begin
      wdt_sys_reset <= fire;
      if (!boot_done) begin
        act_ctrl <= watchdog_boot_fuse;
        state <= (watchdog_boot_fuse[3:0] != 4'h0) ?
                 wwdt_pkg::WWDT_WAIT : wwdt_pkg::WWDT_IDLE;
      end else if (debug_halt) begin
        // A halt returns any non-idle state to waiting so a normal period runs first.
        count <= 14'h0000;
        if (state != wwdt_pkg::WWDT_IDLE) begin
          state <= wwdt_pkg::WWDT_WAIT;
        end
      end else if (apply) begin
        act_ctrl <= ctrl_reg;
        count <= 14'h0000;
        state <= (ctrl_reg.period != 4'h0) ?
                 wwdt_pkg::WWDT_WAIT : wwdt_pkg::WWDT_IDLE;
      end else if (fire) begin
        count <= 14'h0000;
        state <= wwdt_pkg::WWDT_WAIT;
      end else begin
        case (state)
          wwdt_pkg::WWDT_IDLE: begin
            count <= 14'h0000;
          end
          wwdt_pkg::WWDT_WAIT: begin
            if (rst_do) begin
              count <= 14'h0000;
              state <= (act_ctrl.window != 4'h0) ?
                       wwdt_pkg::WWDT_CLOSED : wwdt_pkg::WWDT_WAIT;
            end else if (tick) begin
              count <= 14'(count + 14'h0001);
            end
          end
          wwdt_pkg::WWDT_CLOSED: begin
            if (tick && 14'(count + 14'h0001) >= cur_limit) begin
              count <= 14'h0000;
              state <= wwdt_pkg::WWDT_OPEN;
            end else if (tick) begin
              count <= 14'(count + 14'h0001);
            end
          end
          wwdt_pkg::WWDT_OPEN: begin
            if (rst_do) begin
              count <= 14'h0000;
              state <= wwdt_pkg::WWDT_CLOSED;
            end else if (tick) begin
              count <= 14'(count + 14'h0001);
            end
          end
          default: begin
            state <= wwdt_pkg::WWDT_IDLE;
          end
        endcase
      end
    end
  end

  chk_reset_cause: assert property (
    wdt_sys_reset |-> $past(timeout_hit || early_hit) && $past(state) != wwdt_pkg::WWDT_IDLE
  ) else $error("system reset without timeout or early restart");

  chk_reset_clears: assert property (
    wdt_sys_reset |-> count == 14'h0000 && state == wwdt_pkg::WWDT_WAIT
  ) else $error("counter not cleared by watchdog reset");

  chk_halt_clears: assert property (
    debug_halt && boot_done |=> count == 14'h0000 && !wdt_sys_reset
  ) else $error("halt did not stop and clear the watchdog");

  chk_disabled_idle: assert property (
    boot_done && act_ctrl.period == 4'h0 |-> state == wwdt_pkg::WWDT_IDLE && !wdt_sys_reset
  ) else $error("disabled watchdog is running");

  chk_period_len: assert property (
    act_ctrl.period == 4'h1 && state == wwdt_pkg::WWDT_WAIT |-> cur_limit == 14'h0008
  ) else $error("shortest period is not eight ticks");

  chk_closed_to_open: assert property (
    state == wwdt_pkg::WWDT_CLOSED && !debug_halt && !apply && !fire ##1
    state == wwdt_pkg::WWDT_OPEN |-> count == 14'h0000
  ) else $error("open period did not start from zero");

  chk_first_restart: assert property (
    $past(state) == wwdt_pkg::WWDT_WAIT && state == wwdt_pkg::WWDT_CLOSED
    |-> $past(rst_do) && $past(act_ctrl.window) != 4'h0
  ) else $error("closed period started without restart");

  cov_timeout: cover property ($past(state) == wwdt_pkg::WWDT_OPEN && wdt_sys_reset);
  cov_early: cover property ($past(early_hit) && wdt_sys_reset);
  cov_lock_set: cover property ($rose(lock) && boot_done);
  cov_halt: cover property ($fell(debug_halt) && state == wwdt_pkg::WWDT_WAIT);

endmodule // wwdt_top

// File: wwdt_core_model.sv
// Processor-side model that issues watchdog restart instructions.
`timescale 1ns/100ps
module wwdt_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic kick_req,
  output logic watchdog_restart_instr
);
  // ==========================================
  // Restart issue
  // Each request is copied to the output one edge later, so a held request
  // gives a held restart level, not a single pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_restart_instr <= 1'b0;
    end else begin
      watchdog_restart_instr <= kick_req;
    end
  end
endmodule // wwdt_core_model

// File: tb_top.sv
// Self-checking testbench for the windowed watchdog.
`timescale 1ns/100ps
`include "wwdt_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
  logic kick_req, restart, debug_halt, debug_mode, sys_rst;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] fuse;
  int mismatches, compares;
  assign hready = hreadyout;
  // ==========================================
  // Instances
  // A short tick divider keeps every period to a few hundred cycles.
  wwdt_top #(.TICK_DIV(10)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .watchdog_restart_instr(restart), .debug_halt(debug_halt), .debug_mode(debug_mode),
    .watchdog_boot_fuse(fuse), .wdt_sys_reset(sys_rst));
  wwdt_core_model core (.hclk(hclk), .hresetn(hresetn), .kick_req(kick_req),
    .watchdog_restart_instr(restart));
  // ==========================================
  // Shared tasks
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_ready();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask
  task automatic key();
    bus(1'b1, `WWDT_OFS_KEY, `WWDT_KEY_VAL);
  endtask
  task automatic kick();
    kick_req <= 1'b1;
    @(posedge hclk);
    kick_req <= 1'b0;
  endtask
  // The pulse must land inside a window of cycles and last exactly one cycle.
  task automatic wait_rst(input int lo, input int hi);
    int n;
    n = 0;
    while (sys_rst !== 1'b1 && n <= hi) begin
      @(posedge hclk);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    @(posedge hclk);
    `CHK(sys_rst, 1'b0)
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge hclk);
      if (sys_rst !== 1'b0) seen = 1'b1;
    end
    `CHK(seen, 1'b0)
  endtask
  // ==========================================
  // Scenarios
  task automatic boot_lock();
    wait_rst(60, 100);
    bus(1'b0, `WWDT_OFS_CTRL, 8'h00);
    `CHK(rd, 32'h00000001)
    bus(1'b0, `WWDT_OFS_STATUS, 8'h00);
    `CHK(rd, 32'h00000080)
    key();
    bus(1'b1, `WWDT_OFS_CTRL, 8'h00);
    bus(1'b0, `WWDT_OFS_CTRL, 8'h00);
    `CHK(rd, 32'h00000001)
    debug_mode <= 1'b1;
    key();
    bus(1'b1, `WWDT_OFS_STATUS, 8'h00);
    debug_mode <= 1'b0;
    bus(1'b0, `WWDT_OFS_STATUS, 8'h00);
    `CHK(rd, 32'h00000000)
    $display("boot_lock done");
  endtask
  task automatic prot_write();
    key();
    bus(1'b1, `WWDT_OFS_CTRL, 8'h00);
    repeat (15) @(posedge hclk);
    quiet(200);
    bus(1'b1, `WWDT_OFS_CTRL, 8'h02);
    bus(1'b0, `WWDT_OFS_CTRL, 8'h00);
    `CHK(rd, 32'h00000000)
    bus(1'b0, 8'h0C, 8'h00);
    `CHK(rd, 32'h00000000)
    key();
    bus(1'b1, `WWDT_OFS_CTRL, 8'h02);
    repeat (15) @(posedge hclk);
    bus(1'b0, `WWDT_OFS_STATUS, 8'h00);
    `CHK(rd, 32'h00000000)
    bus(1'b0, `WWDT_OFS_CTRL, 8'h00);
    `CHK(rd, 32'h00000002)
    $display("prot_write done");
  endtask
  task automatic normal_kick();
    repeat (4) begin
      kick();
      quiet(100);
    end
    kick();
    wait_rst(175, 200);
    $display("normal_kick done");
  endtask
  task automatic window_mode();
    key();
    bus(1'b1, `WWDT_OFS_CTRL, 8'h11);
    repeat (15) @(posedge hclk);
    kick();
    quiet(30);
    kick();
    wait_rst(15, 40);
    kick();
    quiet(100);
    kick();
    quiet(60);
    wait_rst(100, 135);
    $display("window_mode done");
  endtask
  // A restart right after the halt would punish an unskipped closed window.
  task automatic debug_stop();
    kick();
    quiet(30);
    debug_halt <= 1'b1;
    quiet(300);
    debug_halt <= 1'b0;
    kick();
    // A second restart while the first still synchronises must be dropped.
    repeat (5) @(posedge hclk);
    kick();
    quiet(40);
    wait_rst(120, 150);
    $display("debug_stop done");
  endtask
  // A second boot with the watchdog fused off must leave it unlocked and idle.
  task automatic boot_off();
    hresetn <= 1'b0;
    fuse <= 8'h10;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    bus(1'b0, `WWDT_OFS_STATUS, 8'h00);
    `CHK(rd, 32'h00000000)
    bus(1'b0, `WWDT_OFS_CTRL, 8'h00);
    `CHK(rd, 32'h00000010)
    quiet(200);
    $display("boot_off done");
  endtask
  // ==========================================
  // Clock and main sequence
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `WWDT_HSIZE_WORD;
    hwdata = 32'h00000000;
    kick_req = 1'b0;
    debug_halt = 1'b0;
    debug_mode = 1'b0;
    fuse = 8'h01;
    mismatches = 0;
    compares = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    boot_lock();
    prot_write();
    normal_kick();
    window_mode();
    debug_stop();
    boot_off();
    end_of_test();
  end
endmodule // tb_top
